/* pkg/tcr_pkg.sv */
// Package: register map, field layout, reset values and state of timer 2
//
// Overview of operation
// - Overflow of the 16-bit count sets the overflow flag.
// - Counting down, count equal to capture pair also sets overflow flag.
// - Overflow flag set by hardware only while both baud selects are 0.
// - Overflow flag cleared only by software; software writing 1 sets it.
// - External flag set by trigger falling edge or up/down wrap events.
// - Hardware never clears the external flag; software write only.
// - Software set or trigger edge on external flag raises timer request.
// - Receive baud select picks timer 1 (0) or this timer (1) overflows.
// - Transmit baud select picks timer 1 (0) or this timer (1) overflows.
// - Either baud select forces baud rate generator mode.
// - Pin enable allows trigger-edge capture/reload unless in baud or up/down mode.
// - Run control starts/stops the timer; stopped count does not step, but enabled trigger edges still reload or capture/clear it.
// - Baud rate generator mode advances once every 2 clocks.
// - Timer select 0 counts at speed-select rate, 1 counts pin falls.
// - In baud mode, ignore capture select and reload on every overflow.
// - Reload mode reloads on overflow and on enabled trigger falling edge.
// - Capture mode copies count into capture pair on enabled trigger edge.
// - Capture auto-clear resets the count once captured.
// - Down count enable plus trigger level set direction in reload mode.
// - Low capture byte takes low count byte; supplies low reload byte.
// - High capture byte takes high count byte; supplies high reload byte.
// - Count readable and writable as low and high bytes, adjacent.
package tcr_pkg;

  // Register offsets on the byte-wide register port
  localparam logic [7:0] TCR_ADDR_CTRL   = 8'hC8;
  localparam logic [7:0] TCR_ADDR_MODE   = 8'hC9;
  localparam logic [7:0] TCR_ADDR_CAP_LO = 8'hCA;
  localparam logic [7:0] TCR_ADDR_CAP_HI = 8'hCB;
  localparam logic [7:0] TCR_ADDR_CNT_LO = 8'hCC;
  localparam logic [7:0] TCR_ADDR_CNT_HI = 8'hCD;

  // Field positions in timer_control
  localparam int TCR_CTL_OVF  = 7;
  localparam int TCR_CTL_EXT  = 6;
  localparam int TCR_CTL_RXS  = 5;
  localparam int TCR_CTL_TXS  = 4;
  localparam int TCR_CTL_EXEN = 3;
  localparam int TCR_CTL_RUN  = 2;
  localparam int TCR_CTL_CTS  = 1;
  localparam int TCR_CTL_CPRL = 0;

  // Field positions in timer_mode_control; other bits read zero
  localparam int         TCR_MOD_ACLR = 3;
  localparam int         TCR_MOD_DOWN_COUNT_ENABLE = 0;
  localparam logic [7:0] TCR_MOD_MASK = 8'h09;

  // Reset values
  localparam logic [7:0]  TCR_CTRL_RST = 8'h00;
  localparam logic [7:0]  TCR_MODE_RST = 8'h00;
  localparam logic [15:0] TCR_CAP_RST  = 16'h0000;
  localparam logic [15:0] TCR_CNT_RST  = 16'h0000;
  localparam logic [15:0] TCR_CNT_MAX  = 16'hFFFF;
  localparam logic [7:0]  TCR_RD_NONE  = 8'h00;

  // Timing counts in core clocks per count step, and the prescaler width
  localparam int TCR_DIV_BAUD = 2;
  localparam int TCR_DIV_SLOW = 12;
  localparam int TCR_DIV_FAST = 4;
  localparam int TCR_PRE_W    = 4;

  // Operating mode, Gray-ordered
  typedef enum logic [1:0] {
    TCR_MODE_RELOAD  = 2'b00,
    TCR_MODE_UPDOWN  = 2'b01,
    TCR_MODE_CAPTURE = 2'b11,
    TCR_MODE_BAUD    = 2'b10
  } tcr_mode_e;

  // Whole state of the block
  typedef struct packed {
    logic [7:0]           ctrl;
    logic [7:0]           mode;
    logic [15:0]          cap;
    logic [15:0]          cnt;
    logic [TCR_PRE_W-1:0] pre;
    logic                 trig_q;
    logic                 pin_q;
    logic [7:0]           rdata;
    logic                 rx_tick;
    logic                 tx_tick;
    logic                 irq;
  } tcr_state_s;

  localparam tcr_state_s TCR_STATE_RST = '{
    ctrl:    TCR_CTRL_RST,
    mode:    TCR_MODE_RST,
    cap:     TCR_CAP_RST,
    cnt:     TCR_CNT_RST,
    pre:     '0,
    trig_q:  1'b1,
    pin_q:   1'b1,
    rdata:   TCR_RD_NONE,
    rx_tick: 1'b0,
    tx_tick: 1'b0,
    irq:     1'b0
  };

endpackage

/* verilog/tcr_timer2.sv */
// Timer 2 with capture, auto-reload, up/down and baud generation
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps

module tcr_timer2
  import tcr_pkg::*;
#(
  parameter int DIV_SLOW = TCR_DIV_SLOW,
  parameter int DIV_FAST = TCR_DIV_FAST
) (
  // Clock, reset, enable
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_clk_en,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Pins and neighbouring blocks
  input  wire logic       i_ext_trigger_pin,
  input  wire logic       i_event_count_pin,
  input  wire logic       i_timer_speed_sel,
  input  wire logic       i_timer1_ovf,
  // Serial time bases and interrupt request
  output logic            o_rx_baud_tick,
  output logic            o_tx_baud_tick,
  output logic            o_timer_irq
);

  // Prescaler terminal values, cut to the prescaler width
  localparam logic [TCR_PRE_W-1:0] PRE_BAUD =
    TCR_PRE_W'(TCR_DIV_BAUD - 1);
  localparam logic [TCR_PRE_W-1:0] PRE_SLOW = TCR_PRE_W'(DIV_SLOW - 1);
  localparam logic [TCR_PRE_W-1:0] PRE_FAST = TCR_PRE_W'(DIV_FAST - 1);

  tcr_state_s s_r;
  tcr_state_s s_nxt;

  logic                 baud_on;
  tcr_mode_e            mode;
  logic                 run;
  logic                 pin_mode;
  logic [TCR_PRE_W-1:0] pre_top;
  logic                 pre_hit;
  logic                 trig_fall;
  logic                 pin_fall;
  logic                 tick;
  logic                 count_up;
  logic                 ovf_up;
  logic                 udf;
  logic                 wrap;
  logic                 ext_evt;
  logic                 ovf_set;
  logic                 ext_set;
  logic                 baud_ovf;
  logic                 wr_ctrl;
  logic                 wr_mode;
  logic                 wr_cap_lo;
  logic                 wr_cap_hi;
  logic                 wr_cnt_lo;
  logic                 wr_cnt_hi;

  // Mode decode and event detection
  always_comb begin
    // Either baud select takes over the timer
    baud_on = s_r.ctrl[TCR_CTL_RXS] | s_r.ctrl[TCR_CTL_TXS];
    if (baud_on) begin
      mode = TCR_MODE_BAUD;
    end else if (s_r.ctrl[TCR_CTL_CPRL]) begin
      mode = TCR_MODE_CAPTURE;
    end else if (s_r.mode[TCR_MOD_DOWN_COUNT_ENABLE]) begin
      mode = TCR_MODE_UPDOWN;
    end else begin
      mode = TCR_MODE_RELOAD;
    end

    run = s_r.ctrl[TCR_CTL_RUN];
    // Baud mode ignores the counter/timer select
    pin_mode = s_r.ctrl[TCR_CTL_CTS] & ~baud_on;

    // Falling edges; pins are already synchronous to the core clock
    trig_fall = s_r.trig_q & ~i_ext_trigger_pin;
    pin_fall  = s_r.pin_q & ~i_event_count_pin;

    // Count step period
    if (baud_on) begin
      pre_top = PRE_BAUD;
    end else if (i_timer_speed_sel) begin
      pre_top = PRE_FAST;
    end else begin
      pre_top = PRE_SLOW;
    end
    // Compare with >= so a divider change never strands the prescaler
    pre_hit = (s_r.pre >= pre_top);

    if (!run) begin
      tick = 1'b0;
    end else if (pin_mode) begin
      tick = pin_fall;
    end else begin
      tick = pre_hit;
    end

    // Direction follows the trigger level only in up/down mode
    count_up = (mode != TCR_MODE_UPDOWN) | i_ext_trigger_pin;
    ovf_up   = tick & count_up & (s_r.cnt == TCR_CNT_MAX);
    udf      = tick & ~count_up & (s_r.cnt == s_r.cap);
    wrap     = ovf_up | udf;

    // Trigger edge acts only when enabled and not generating baud clocks or counting up/down
    ext_evt = s_r.ctrl[TCR_CTL_EXEN] & trig_fall &
              ((mode == TCR_MODE_RELOAD) ||
               (mode == TCR_MODE_CAPTURE));

    // Flag set terms
    ovf_set = wrap & ~baud_on;
    ext_set = ext_evt |
              (wrap & (mode == TCR_MODE_UPDOWN));
    baud_ovf = ovf_up & baud_on;

    // Register write decode
    wr_ctrl   = i_wr & (i_addr == TCR_ADDR_CTRL);
    wr_mode   = i_wr & (i_addr == TCR_ADDR_MODE);
    wr_cap_lo = i_wr & (i_addr == TCR_ADDR_CAP_LO);
    wr_cap_hi = i_wr & (i_addr == TCR_ADDR_CAP_HI);
    wr_cnt_lo = i_wr & (i_addr == TCR_ADDR_CNT_LO);
    wr_cnt_hi = i_wr & (i_addr == TCR_ADDR_CNT_HI);
  end

  // Next state
  always_comb begin
    s_nxt = s_r;

    // Edge history
    s_nxt.trig_q = i_ext_trigger_pin;
    s_nxt.pin_q  = i_event_count_pin;

    // Prescaler runs only while the timer runs on the core clock
    if (run && !pin_mode) begin
      if (pre_hit) begin
        s_nxt.pre = '0;
      end else begin
        s_nxt.pre = s_r.pre + 1'b1;
      end
    end

    // Count step, wrap and reload
    if (tick) begin
      if (ovf_up) begin
        if (mode == TCR_MODE_CAPTURE) begin
          s_nxt.cnt = TCR_CNT_RST;
        end else begin
          s_nxt.cnt = s_r.cap;
        end
      end else if (udf) begin
        s_nxt.cnt = TCR_CNT_MAX;
      end else if (count_up) begin
        s_nxt.cnt = s_r.cnt + 16'h0001;
      end else begin
        s_nxt.cnt = s_r.cnt - 16'h0001;
      end
    end

    // Trigger edge: capture or reload
    if (ext_evt) begin
      if (mode == TCR_MODE_CAPTURE) begin
        s_nxt.cap = s_r.cnt;
        if (s_r.mode[TCR_MOD_ACLR]) begin
          s_nxt.cnt = TCR_CNT_RST;
        end
      end else begin
        s_nxt.cnt = s_r.cap;
      end
    end

    // Software writes; a count byte write overrides the step
    if (wr_ctrl) begin
      s_nxt.ctrl = i_wdata;
    end
    if (wr_mode) begin
      s_nxt.mode = i_wdata & TCR_MOD_MASK;
    end
    // Hardware capture beats a software write to the capture pair
    if (wr_cap_lo && !(ext_evt && mode == TCR_MODE_CAPTURE)) begin
      s_nxt.cap[7:0] = i_wdata;
    end
    if (wr_cap_hi && !(ext_evt && mode == TCR_MODE_CAPTURE)) begin
      s_nxt.cap[15:8] = i_wdata;
    end
    if (wr_cnt_lo) begin
      s_nxt.cnt[7:0] = i_wdata;
    end
    if (wr_cnt_hi) begin
      s_nxt.cnt[15:8] = i_wdata;
    end

    // Hardware sets win over a software clear in the same cycle
    if (ovf_set) begin
      s_nxt.ctrl[TCR_CTL_OVF] = 1'b1;
    end
    if (ext_set) begin
      s_nxt.ctrl[TCR_CTL_EXT] = 1'b1;
    end

    // Serial time bases
    if (s_r.ctrl[TCR_CTL_RXS]) begin
      s_nxt.rx_tick = baud_ovf;
    end else begin
      s_nxt.rx_tick = i_timer1_ovf;
    end
    if (s_r.ctrl[TCR_CTL_TXS]) begin
      s_nxt.tx_tick = baud_ovf;
    end else begin
      s_nxt.tx_tick = i_timer1_ovf;
    end

    // Request follows the flags as they will be registered
    s_nxt.irq = s_nxt.ctrl[TCR_CTL_OVF] |
                s_nxt.ctrl[TCR_CTL_EXT];

    // Read data stand for one cycle only
    s_nxt.rdata = TCR_RD_NONE;
    if (i_rd) begin
      case (i_addr)
        TCR_ADDR_CTRL: begin
          s_nxt.rdata = s_r.ctrl;
        end
        TCR_ADDR_MODE: begin
          s_nxt.rdata = s_r.mode;
        end
        TCR_ADDR_CAP_LO: begin
          s_nxt.rdata = s_r.cap[7:0];
        end
        TCR_ADDR_CAP_HI: begin
          s_nxt.rdata = s_r.cap[15:8];
        end
        TCR_ADDR_CNT_LO: begin
          s_nxt.rdata = s_r.cnt[7:0];
        end
        TCR_ADDR_CNT_HI: begin
          s_nxt.rdata = s_r.cnt[15:8];
        end
        default: begin
          s_nxt.rdata = TCR_RD_NONE;
        end
      endcase
    end
  end

  // State register; the enable freezes everything
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_r <= TCR_STATE_RST;
    end else if (i_clk_en) begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign o_rdata        = s_r.rdata;
  assign o_rx_baud_tick = s_r.rx_tick;
  assign o_tx_baud_tick = s_r.tx_tick;
  assign o_timer_irq    = s_r.irq;

endmodule

/* tb/tcr_timer2_sva.sv */
// Port-level checker for the timer 2 block
`timescale 1ns/100ps
module tcr_timer2_sva import tcr_pkg::*; (
  // Clock, reset and register port
  input wire logic       i_ref_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_clk_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  // Time bases and request
  input wire logic       i_timer1_ovf,
  input wire logic       o_rx_baud_tick,
  input wire logic       o_tx_baud_tick,
  input wire logic       o_timer_irq
);
  logic       wr_c;
  logic [1:0] baud_r;
  assign wr_c = i_clk_en && i_wr && i_addr == TCR_ADDR_CTRL;
  // Shadow of the baud selects; only software moves them
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) baud_r <= 2'b00;
    else if (wr_c) baud_r <= i_wdata[5:4];
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  chk_rd_quiet: assert property (
    $past(i_clk_en) && !$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its slot");
  chk_rd_unmapped: assert property (
    i_clk_en && i_rd && (i_addr < TCR_ADDR_CTRL || i_addr > TCR_ADDR_CNT_HI)
    |=> o_rdata == 8'h00) else $error("unmapped read not zero");
  chk_mode_rsvd: assert property (
    i_clk_en && i_rd && i_addr == TCR_ADDR_MODE
    |=> (o_rdata & ~TCR_MOD_MASK) == 8'h00) else $error("reserved bits set");
  chk_irq_swset: assert property (
    wr_c && (i_wdata[7] || i_wdata[6]) |=> o_timer_irq)
    else $error("software set gave no request");
  chk_irq_hold: assert property (
    o_timer_irq && !wr_c |=> o_timer_irq) else $error("flag lost");
  chk_baud_noflag: assert property (
    baud_r != 2'b00 && !o_timer_irq && !wr_c |=> !o_timer_irq)
    else $error("flag set in baud mode");
  chk_rx_t1: assert property (
    i_clk_en && !baud_r[1] && !wr_c |=> o_rx_baud_tick == $past(i_timer1_ovf))
    else $error("rx tick not from timer 1");
  chk_tx_t1: assert property (
    i_clk_en && !baud_r[0] && !wr_c |=> o_tx_baud_tick == $past(i_timer1_ovf))
    else $error("tx tick not from timer 1");
  chk_rx_gap: assert property (
    baud_r[1] && $stable(baud_r) && o_rx_baud_tick |=> !o_rx_baud_tick)
    else $error("own baud ticks too close");
endmodule
bind tcr_timer2 tcr_timer2_sva i_tcr_timer2_sva (.*);

/* tb/tcr_pins_model.sv */
// Pin-side model: trigger pin, event pin and timer 1 overflow
`timescale 1ns/100ps
module tcr_pins_model #(
  parameter int T1_DIV = 8
) (
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_trig_lvl,
  input  wire logic i_evt_lvl,
  output logic      o_trig,
  output logic      o_evt,
  output logic      o_t1_ovf
);
  int div_r;
  // Pins idle high; timer 1 overflows on a fixed period
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_trig   <= 1'b1;
      o_evt    <= 1'b1;
      o_t1_ovf <= 1'b0;
      div_r    <= 0;
    end else begin
      o_trig   <= i_trig_lvl;
      o_evt    <= i_evt_lvl;
      div_r    <= (div_r == T1_DIV - 1) ? 0 : div_r + 1;
      o_t1_ovf <= (div_r == T1_DIV - 1);
    end
  end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the timer 2 block
`timescale 1ns/100ps
module testbench import tcr_pkg::*;;
  localparam int T1 = 8;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       tlv = 1'b1;
  logic       elv = 1'b1;
  logic       cen = 1'b1;
  logic       spd = 1'b1;
  logic [7:0] rdata;
  logic       trig, evt, t1, rx, tx, irq;
  int         failures = 0;
  int         checks = 0;
  // Core clock
  initial begin
    forever #4 clk = ~clk;
  end
  // Block and its pin-side partner
  tcr_timer2 i_tcr_timer2 (.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(cen),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_ext_trigger_pin(trig), .i_event_count_pin(evt),
    .i_timer_speed_sel(spd), .i_timer1_ovf(t1), .o_rx_baud_tick(rx),
    .o_tx_baud_tick(tx), .o_timer_irq(irq));
  tcr_pins_model #(.T1_DIV(T1)) i_tcr_pins_model (.i_ref_clk(clk),
    .i_sys_rst(rst), .i_trig_lvl(tlv), .i_evt_lvl(elv), .o_trig(trig),
    .o_evt(evt), .o_t1_ovf(t1));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, e, input logic [7:0] m = 8'hFF);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(rdata & m, e);
  endtask
  task automatic ld(input logic [7:0] cl, ch, nl, nh);
    wrr(TCR_ADDR_CAP_LO, cl);
    wrr(TCR_ADDR_CAP_HI, ch);
    wrr(TCR_ADDR_CNT_LO, nl);
    wrr(TCR_ADDR_CNT_HI, nh);
  endtask
  task automatic fall;
    @(posedge clk);
    tlv <= 1'b0;
    repeat (4) @(posedge clk);
    tlv <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_regs;
    rdc(TCR_ADDR_CTRL, 8'h00);
    wrr(TCR_ADDR_MODE, 8'hFF);
    rdc(TCR_ADDR_MODE, 8'h09);
    wrr(TCR_ADDR_MODE, 8'h00);
    rdc(8'hC7, 8'h00);
    ld(8'h00, 8'h00, 8'h5A, 8'hA5);
    repeat (40) @(posedge clk);
    rdc(TCR_ADDR_CNT_LO, 8'h5A);
    rdc(TCR_ADDR_CNT_HI, 8'hA5);
  endtask
  task automatic t_reload;
    ld(8'hFE, 8'hFF, 8'hFD, 8'hFF);
    wrr(TCR_ADDR_CTRL, 8'h04);
    repeat (30) @(posedge clk);
    rdc(TCR_ADDR_CTRL, 8'h84);
    rdc(TCR_ADDR_CNT_HI, 8'hFF);
    chk({7'h00, irq}, 8'h01);
    // Stop first so a late overflow cannot beat the flag clear
    wrr(TCR_ADDR_CTRL, 8'h80);
    rdc(TCR_ADDR_CTRL, 8'h80);
    wrr(TCR_ADDR_CTRL, 8'h00);
    rdc(TCR_ADDR_CTRL, 8'h00);
  endtask
  task automatic t_capture;
    // Count differs from the reload value, so the reload is visible
    wrr(TCR_ADDR_CNT_LO, 8'h33);
    wrr(TCR_ADDR_CTRL, 8'h08);
    fall;
    rdc(TCR_ADDR_CNT_LO, 8'hFE);
    wrr(TCR_ADDR_CTRL, 8'h01);
    ld(8'hFE, 8'hFF, 8'h34, 8'h12);
    fall;
    rdc(TCR_ADDR_CAP_LO, 8'hFE);
    wrr(TCR_ADDR_MODE, 8'h08);
    wrr(TCR_ADDR_CTRL, 8'h09);
    fall;
    rdc(TCR_ADDR_CAP_LO, 8'h34);
    rdc(TCR_ADDR_CAP_HI, 8'h12);
    rdc(TCR_ADDR_CNT_HI, 8'h00);
    rdc(TCR_ADDR_CTRL, 8'h49);
    chk({7'h00, irq}, 8'h01);
    wrr(TCR_ADDR_CTRL, 8'h00);
    wrr(TCR_ADDR_MODE, 8'h00);
  endtask
  task automatic t_baud(input logic [7:0] c, input int er, et);
    int nr = 0;
    int nt = 0;
    ld(8'hFE, 8'hFF, 8'hFE, 8'hFF);
    wrr(TCR_ADDR_CTRL, c);
    repeat (80) begin
      @(posedge clk);
      #1;
      nr += int'(rx);
      nt += int'(tx);
    end
    chk({7'h00, nr >= er - 1 && nr <= er + 1}, 8'h01);
    chk({7'h00, nt >= et - 1 && nt <= et + 1}, 8'h01);
    rdc(TCR_ADDR_CTRL, 8'h00, 8'h80);
    wrr(TCR_ADDR_CTRL, 8'h00);
  endtask
  task automatic t_counter;
    ld(8'h00, 8'h00, 8'h00, 8'h00);
    wrr(TCR_ADDR_CTRL, 8'h06);
    repeat (3) begin
      @(posedge clk);
      elv <= 1'b0;
      repeat (3) @(posedge clk);
      elv <= 1'b1;
      repeat (3) @(posedge clk);
    end
    wrr(TCR_ADDR_CTRL, 8'h00);
    rdc(TCR_ADDR_CNT_LO, 8'h03);
  endtask
  task automatic t_updown;
    @(posedge clk);
    tlv <= 1'b0;
    wrr(TCR_ADDR_MODE, 8'h01);
    ld(8'h10, 8'h00, 8'h12, 8'h00);
    wrr(TCR_ADDR_CTRL, 8'h04);
    repeat (20) @(posedge clk);
    rdc(TCR_ADDR_CTRL, 8'h80, 8'h80);
    rdc(TCR_ADDR_CNT_HI, 8'hFF);
    wrr(TCR_ADDR_CTRL, 8'h00);
    wrr(TCR_ADDR_MODE, 8'h00);
  endtask
  // Slow rate; enable held low mid-run, so only 48 enabled run edges count
  task automatic t_slow;
    ld(8'h00, 8'h00, 8'h00, 8'h00);
    spd <= 1'b0;
    wrr(TCR_ADDR_CTRL, 8'h04);
    repeat (20) @(posedge clk);
    cen <= 1'b0;
    repeat (24) @(posedge clk);
    cen <= 1'b1;
    repeat (26) @(posedge clk);
    wrr(TCR_ADDR_CTRL, 8'h00);
    spd <= 1'b1;
    rdc(TCR_ADDR_CNT_LO, 8'(48 / TCR_DIV_SLOW));
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence after a four-cycle reset
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_reload;
    t_capture;
    t_baud(8'h25, 80 / (2 * TCR_DIV_BAUD), 80 / T1);
    t_baud(8'h14, 80 / T1, 80 / (2 * TCR_DIV_BAUD));
    t_counter;
    t_updown;
    t_slow;
    wrap_up;
  end
  // Watchdog well beyond the few hundred cycles needed
  initial begin
    #100000;
    failures++;
    wrap_up;
  end
endmodule
